// ==== hw/binary_counter.sv ====
// Eight-stage binary counter stepped on falling time-base edges
`timescale 1ns/1ps
module binary_counter
   import timer_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   timer_if.counter ctr
);
   logic prev_reg;
   logic [COUNT_WIDTH-1:0] count_reg;
   logic fall;

   assign fall = prev_reg && !ctr.tbo_level;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= ctr.tbo_level;
      end
   end

   // A clamped-low pin gives no edge, so the count holds
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= COUNT_RESET;
      end else if (!ctr.run) begin
         count_reg <= COUNT_RESET;
      end else if (fall) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   assign ctr.count = count_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_count_step: assert property (ctr.run && fall ##1 ctr.run |-> count_reg == $past(count_reg) + 8'h01)
      else $error("counter missed a falling edge");
   a_count_hold: assert property (ctr.run && !ctr.tbo_level && !prev_reg ##1 ctr.run |-> $stable(count_reg))
      else $error("counter moved while clamped");
   a_count_wrap: assert property (ctr.run && fall && count_reg == 8'hFF ##1 ctr.run |-> count_reg == 8'h00)
      else $error("counter did not wrap after 256 states");
endmodule : binary_counter

// ==== hw/programmable_binary_timer.sv ====
// Top of the programmable binary timer with open-drain outputs
// Notes on behaviour
// - Self-reset: bus low N periods, N 1..255
// - Tied bus is low if any output low
// - Chained units: weight 128 output clocks second
// - No feedback: count forever until master reset
// - Master reset halts base, releases all outputs
// - Continuous mode triggers itself once at start
// - Free-run pattern repeats at highest tied bit
// - Narrowest pulse set by lowest tied bit
// - External clock: count each falling edge
// - Synthesizer: one-period pulse every N+1 periods
// - Counter walks 256 equal states, one per period
// - Clamped time-base pin freezes the count
// - Count readable as 8-bit word, MSB weight 128
// - Triggers ignored while a cycle runs
// - Trigger beats simultaneous master reset
// - Trigger starts base, drives all outputs low
`timescale 1ns/1ps
module programmable_binary_timer
   import timer_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic trigger_i,
   input wire logic master_reset_in_i,
   input wire logic timing_network_pin_i,
   input wire logic time_base_out_i,
   input wire logic output_bus_i,
   input wire logic self_reset_i,
   input wire logic synth_mode_i,
   input wire logic auto_trigger_i,
   output logic time_base_out_o,
   output logic time_base_out_oe_o,
   output logic [COUNT_WIDTH-1:0] weighted_count_outputs_o,
   output logic [COUNT_WIDTH-1:0] weighted_count_outputs_oe_o,
   output logic [COUNT_WIDTH-1:0] count_value_o,
   output logic synth_pulse_o,
   output logic busy_o
);
   typedef enum logic [1:0] {IDLE, RUN, GAP} timer_state_type;

   timer_state_type state_reg;
   timer_state_type state_next;
   logic [PIN_COUNT-1:0] pins;
   logic [PIN_COUNT-1:0] sync1_reg;
   logic [PIN_COUNT-1:0] sync2_reg;
   logic trig_prev_reg;
   logic mr_prev_reg;
   logic bus_prev_reg;
   logic tbo_prev_reg;
   logic [1:0] boot_reg;
   logic trig_rise;
   logic mr_rise;
   logic bus_rise;
   logic tbo_fall;
   logic auto_fire;
   logic start;
   logic restart;
   logic self_end;
   logic drive_level_reg;
   logic tbo_oe_reg;
   logic [COUNT_WIDTH-1:0] oe_reg;
   logic [COUNT_WIDTH-1:0] count_out_reg;
   logic synth_reg;
   logic busy_reg;
   logic [3:0] fall_delay_reg;
   logic gap_fall;

   timer_if link ();

   time_base_gen u_time_base (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .tb(link.timebase)
   );

   binary_counter u_counter (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ctr(link.counter)
   );

   assign pins = {auto_trigger_i, synth_mode_i, self_reset_i, timing_network_pin_i,
                  output_bus_i, time_base_out_i, master_reset_in_i, trigger_i};

   // Every pin is asynchronous to clk_i
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_reg <= SYNC_RESET;
         sync2_reg <= SYNC_RESET;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         trig_prev_reg <= 1'b0;
         mr_prev_reg <= 1'b0;
         bus_prev_reg <= 1'b1;
         tbo_prev_reg <= 1'b1;
      end else begin
         trig_prev_reg <= sync2_reg[PIN_TRIG];
         mr_prev_reg <= sync2_reg[PIN_MR];
         bus_prev_reg <= sync2_reg[PIN_BUS];
         tbo_prev_reg <= sync2_reg[PIN_TBO];
      end
   end

   assign trig_rise = sync2_reg[PIN_TRIG] && !trig_prev_reg;
   assign mr_rise = sync2_reg[PIN_MR] && !mr_prev_reg;
   assign bus_rise = sync2_reg[PIN_BUS] && !bus_prev_reg;
   assign tbo_fall = tbo_prev_reg && !sync2_reg[PIN_TBO];

   // Gap exit lags the edge as long as the bus path lags the count,
   // so the synthesizer pulse spans a whole base period
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fall_delay_reg <= 4'h0;
      end else begin
         fall_delay_reg <= {fall_delay_reg[2:0], tbo_fall};
      end
   end

   assign gap_fall = fall_delay_reg[3];

   // Waits until the strap has crossed the synchroniser, then fires once
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         boot_reg <= 2'h0;
      end else if (boot_reg != BOOT_DONE) begin
         boot_reg <= boot_reg + 2'h1;
      end
   end

   assign auto_fire = (boot_reg == BOOT_FIRE) && sync2_reg[PIN_AUTO];
   assign start = trig_rise || auto_fire;
   assign restart = (state_reg != IDLE) && trig_rise && mr_rise;
   // Edge, not level: the bus still reads high for a few cycles after a start
   assign self_end = sync2_reg[PIN_SELF] && bus_rise;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         IDLE: begin
            if (start) begin
               state_next = RUN;
            end
         end
         RUN: begin
            if (restart) begin
               state_next = RUN;
            end else if (mr_rise) begin
               state_next = IDLE;
            end else if (self_end) begin
               state_next = sync2_reg[PIN_SYNTH] ? GAP : IDLE;
            end
         end
         GAP: begin
            if (restart) begin
               state_next = RUN;
            end else if (mr_rise) begin
               state_next = IDLE;
            end else if (gap_fall) begin
               state_next = RUN;
            end
         end
      endcase
   end

   // Other triggers fall through the RUN arm unseen
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Base runs through the synthesizer gap so it is timed by one period
   assign link.tb_enable = (state_reg != IDLE) && sync2_reg[PIN_NET];
   assign link.run = (state_reg == RUN) && !restart;
   assign link.tbo_level = sync2_reg[PIN_TBO];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         drive_level_reg <= 1'b0;
      end else begin
         drive_level_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tbo_oe_reg <= 1'b0;
      end else begin
         tbo_oe_reg <= link.tb_low;
      end
   end

   // Each drain pulls low only for a zero bit, so tied drains sum their weights
   generate
      for (genvar b = 0; b < COUNT_WIDTH; b++) begin : g_drain
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               oe_reg[b] <= 1'b0;
            end else begin
               oe_reg[b] <= (state_reg == RUN) && !link.count[b];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_out_reg <= COUNT_RESET;
         synth_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         count_out_reg <= link.count;
         synth_reg <= (state_reg == GAP);
         busy_reg <= (state_reg != IDLE);
      end
   end

   assign time_base_out_o = drive_level_reg;
   assign time_base_out_oe_o = tbo_oe_reg;
   assign weighted_count_outputs_o = {COUNT_WIDTH{drive_level_reg}};
   assign weighted_count_outputs_oe_o = oe_reg;
   assign count_value_o = count_out_reg;
   assign synth_pulse_o = synth_reg;
   assign busy_o = busy_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_abort;
      state_reg == RUN && mr_rise && !trig_rise;
   endsequence

   sequence s_released;
      state_reg == IDLE ##1 weighted_count_outputs_oe_o == 8'h00 && !time_base_out_oe_o;
   endsequence

   sequence s_gap_entry;
      state_reg == RUN && self_end && !mr_rise && !trig_rise && sync2_reg[PIN_SYNTH];
   endsequence

   a_master_reset: assert property (s_abort |=> s_released)
      else $error("master reset did not release outputs");
   a_trigger_wins: assert property (state_reg == RUN && mr_rise && trig_rise |=> state_reg == RUN)
      else $error("master reset beat a simultaneous trigger");
   a_start_low: assert property (state_reg == IDLE && start |=> state_reg == RUN ##1
                                 weighted_count_outputs_oe_o == 8'hFF)
      else $error("trigger did not drive all outputs low");
   a_ignore_trig: assert property (state_reg == RUN && trig_rise && !mr_rise && !self_end
                                   |=> state_reg == RUN && $past(link.count) != 8'h00
                                   |-> link.count != 8'h00)
      else $error("trigger restarted a running cycle");
   a_free_run: assert property (state_reg == RUN && !sync2_reg[PIN_SELF] && !mr_rise |=> state_reg == RUN)
      else $error("free-running cycle stopped without master reset");
   a_self_end: assert property (state_reg == RUN && self_end && !mr_rise && !sync2_reg[PIN_SYNTH]
                                |=> s_released)
      else $error("bus high did not end the self-reset cycle");
   a_drain_map: assert property ($past(state_reg == RUN) |-> weighted_count_outputs_oe_o == ~count_value_o)
      else $error("drain enables disagree with the count");
   a_idle_word: assert property (state_reg == IDLE [*2] |=> count_value_o == 8'h00)
      else $error("count word not zero while idle");
   a_synth_gap: assert property (s_gap_entry |=> state_reg == GAP ##1 synth_pulse_o)
      else $error("synthesizer pulse missing");
   a_gap_hold: assert property (state_reg == GAP && !gap_fall && !mr_rise |=> state_reg == GAP)
      else $error("synthesizer gap shorter than one period");
   a_auto_start: assert property (state_reg == IDLE && auto_fire |=> state_reg == RUN)
      else $error("continuous mode did not start itself");
endmodule : programmable_binary_timer

// ==== hw/time_base_gen.sv ====
// Internal time base: one low pulse per period T
`timescale 1ns/1ps
module time_base_gen
   import timer_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   timer_if.timebase tb
);
   logic [TB_PHASE_WIDTH-1:0] phase_reg;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase_reg <= '0;
      end else if (!tb.tb_enable) begin
         phase_reg <= '0;
      end else if (phase_reg == TB_PHASE_WIDTH'(TB_PERIOD_CYCLES - 1)) begin
         phase_reg <= '0;
      end else begin
         phase_reg <= phase_reg + 1'b1;
      end
   end

   // Low for the tail of each period, so the falling edge lands once per T
   assign tb.tb_low = tb.tb_enable && (phase_reg >= TB_PHASE_WIDTH'(TB_PERIOD_CYCLES - TBO_LOW_CYCLES));

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_tb_off_high: assert property (!tb.tb_enable |=> phase_reg == '0 && (tb.tb_enable || !tb.tb_low))
      else $error("time base pulses while disabled");
endmodule : time_base_gen

// ==== include/timer_if.sv ====
// Signals shared by the control, time base and counter
`timescale 1ns/1ps
interface timer_if;
   logic run;
   logic tb_enable;
   logic tb_low;
   logic tbo_level;
   logic [7:0] count;
   modport control (output run, output tb_enable, output tbo_level, input tb_low, input count);
   modport timebase (input tb_enable, output tb_low);
   modport counter (input run, input tbo_level, output count);
endinterface : timer_if

// ==== include/timer_pkg.sv ====
// Shared constants for the programmable binary timer
package timer_pkg;
   localparam int COUNT_WIDTH = 8;
   localparam int CLK_PERIOD_PS = 5000;
   // Internal time-base period T and the least low time of its pulse
   localparam int TB_PERIOD_NS = 2000;
   localparam int TB_PERIOD_CYCLES = (TB_PERIOD_NS * 1000) / CLK_PERIOD_PS;
   localparam int TBO_LOW_NS = 500;
   localparam int TBO_LOW_CYCLES = (TBO_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TB_PHASE_WIDTH = $clog2(TB_PERIOD_CYCLES);
   localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 8'h00;
   localparam logic [COUNT_WIDTH-1:0] ALL_DRIVEN = 8'hFF;
   // Positions of the synchronised pins
   localparam int PIN_TRIG = 0;
   localparam int PIN_MR = 1;
   localparam int PIN_TBO = 2;
   localparam int PIN_BUS = 3;
   localparam int PIN_NET = 4;
   localparam int PIN_SELF = 5;
   localparam int PIN_SYNTH = 6;
   localparam int PIN_AUTO = 7;
   localparam int PIN_COUNT = 8;
   // Pulled-up pins (time base, bus) idle high
   localparam logic [PIN_COUNT-1:0] SYNC_RESET = 8'h0C;
   localparam logic [1:0] BOOT_FIRE = 2'h2;
   localparam logic [1:0] BOOT_DONE = 2'h3;
endpackage : timer_pkg

// ==== verif/test_programmable_binary_timer.sv ====
// Self-checking bench for the programmable binary timer
`timescale 1ns/1ps
module test_programmable_binary_timer;
   import timer_pkg::*;
   logic clk = 1'b0, reset = 1'b1, tnp = 1'b1, self_rst = 1'b0, synth = 1'b0;
   logic auto = 1'b0, ext_run = 1'b0, clamp = 1'b0;
   logic [7:0] mask = 8'h00;
   logic trig, mr, pin, bus, tbo_oe, synth_pulse, busy;
   logic [7:0] out_oe, count;
   int errors = 0, checks_done = 0;
   always #2.5 clk = ~clk;
   programmable_binary_timer dut (.clk_i(clk), .reset_i(reset), .trigger_i(trig), .master_reset_in_i(mr),
      .timing_network_pin_i(tnp), .time_base_out_i(pin), .output_bus_i(bus), .self_reset_i(self_rst),
      .synth_mode_i(synth), .auto_trigger_i(auto), .time_base_out_o(), .time_base_out_oe_o(tbo_oe),
      .weighted_count_outputs_o(), .weighted_count_outputs_oe_o(out_oe), .count_value_o(count),
      .synth_pulse_o(synth_pulse), .busy_o(busy));
   timer_partner far (.clk_i(clk), .tbo_oe_i(tbo_oe), .out_oe_i(out_oe), .mask_i(mask), .ext_run_i(ext_run),
      .clamp_i(clamp), .trigger_o(trig), .master_reset_o(mr), .pin_o(pin), .bus_o(bus));
   task automatic check_val(input logic [7:0] actual, input logic [7:0] expected);
      checks_done++;
      if (actual !== expected) begin
         errors++;
         $display("MISMATCH t=%0t actual=%h expected=%h", $time, actual, expected);
      end
   endtask : check_val
   task automatic check_span(input int actual, input int lo, input int hi);
      checks_done++;
      if (actual < lo || actual > hi) begin
         errors++;
         $display("MISMATCH t=%0t span=%h limits=%h..%h", $time, actual, lo, hi);
      end
   endtask : check_span
   task automatic stop_test();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   function automatic logic probe(input int which);
      return (which == 0) ? bus : (which == 1) ? busy : synth_pulse;
   endfunction : probe
   // Counts falling clock edges until the level shows, bounded
   task automatic wait_level(input int which, input logic level, input int limit, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (probe(which) !== level && n < limit);
   endtask : wait_level
   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask : cycles
   task automatic do_reset();
      @(posedge clk);
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
   endtask : do_reset
   // Stopping at phase 0 leaves the pin high, so k falls exactly
   task automatic ext_span(input int k);
      @(posedge clk);
      ext_run <= 1'b1;
      repeat (8 * k) @(posedge clk);
      ext_run <= 1'b0;
      cycles(10);
   endtask : ext_span
   task automatic t_auto();
      int n;
      @(posedge clk);
      auto <= 1'b1;
      do_reset();
      wait_level(1, 1'b1, 20, n);
      check_val({7'h00, busy}, 8'h01);
      far.pulse(1'b0, 1'b1);
      cycles(6);
      check_val({7'h00, busy}, 8'h00);
      @(posedge clk);
      auto <= 1'b0;
   endtask : t_auto
   // A late trigger would stretch the low time past the limit
   task automatic t_mono(input logic [7:0] m, input int n);
      int a, b;
      @(posedge clk);
      self_rst <= 1'b1;
      mask <= m;
      fork
         far.pulse(1'b1, 1'b0);
      join_none
      wait_level(0, 1'b0, 20, a);
      check_val(out_oe, 8'hFF);
      cycles(200);
      far.pulse(1'b1, 1'b0);
      wait_level(0, 1'b1, n * 400, b);
      check_span(b + 209, (n - 1) * 400 + 300, n * 400 + 20);
      cycles(8);
      check_val({busy, out_oe[6:0]}, 8'h00);
   endtask : t_mono
   task automatic t_ext();
      @(posedge clk);
      self_rst <= 1'b0;
      tnp <= 1'b0;
      mask <= 8'h00;
      far.pulse(1'b1, 1'b0);
      cycles(10);
      check_val(out_oe, 8'hFF);
      ext_span(3);
      check_val(count, 8'h03);
      check_val(out_oe, 8'hFC);
      ext_span(252);
      check_val(count, 8'hFF);
      check_val({out_oe[6:0], tbo_oe}, 8'h00);
      ext_span(1);
      check_val(count, 8'h00);
      check_val(out_oe, 8'hFF);
      far.pulse(1'b0, 1'b1);
   endtask : t_ext
   task automatic t_clamp();
      int a;
      @(posedge clk);
      tnp <= 1'b1;
      fork
         far.pulse(1'b1, 1'b0);
      join_none
      wait_level(1, 1'b1, 20, a);
      cycles(420);
      @(posedge clk);
      clamp <= 1'b1;
      cycles(10);
      check_val(count, 8'h02);
      cycles(900);
      check_val(count, 8'h02);
      @(posedge clk);
      clamp <= 1'b0;
      far.pulse(1'b1, 1'b1);
      cycles(2);
      check_val({busy, count[6:0]}, 8'h80);
      check_val(out_oe, 8'hFF);
      far.pulse(1'b0, 1'b1);
      cycles(6);
      check_val({out_oe[5:0], busy, tbo_oe}, 8'h00);
      check_val(count, 8'h00);
   endtask : t_clamp
   task automatic t_synth();
      int a, w, p;
      @(posedge clk);
      self_rst <= 1'b1;
      synth <= 1'b1;
      tnp <= 1'b0;
      mask <= 8'h03;
      far.pulse(1'b1, 1'b0);
      @(posedge clk);
      ext_run <= 1'b1;
      wait_level(2, 1'b1, 100, a);
      wait_level(2, 1'b0, 20, w);
      wait_level(2, 1'b1, 40, p);
      check_span(w, 7, 9);
      check_span(w + p, 31, 33);
      @(posedge clk);
      ext_run <= 1'b0;
      far.pulse(1'b0, 1'b1);
   endtask : t_synth
   initial begin
      do_reset();
      t_auto();
      t_mono(8'h01, 1);
      t_mono(8'h05, 5);
      t_ext();
      t_clamp();
      t_synth();
      stop_test();
   end
   // Tests need about 6000 cycles; a hang is cut well after that
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test();
   end
endmodule : test_programmable_binary_timer

// ==== verif/timer_partner.sv ====
// Far-side model: trigger, reset and clock sources, wired pins
`timescale 1ns/1ps
module timer_partner (
   input wire logic clk_i,
   input wire logic tbo_oe_i,
   input wire logic [7:0] out_oe_i,
   input wire logic [7:0] mask_i,
   input wire logic ext_run_i,
   input wire logic clamp_i,
   output logic trigger_o,
   output logic master_reset_o,
   output logic pin_o,
   output logic bus_o
);
   logic [2:0] phase_reg;
   initial begin
      trigger_o = 1'b0;
      master_reset_o = 1'b0;
   end
   // Pull-up bus, low while any tied output pulls
   assign bus_o = ~|(out_oe_i & mask_i);
   // Clock 4 high, 4 low; a clamp wins over both drivers
   assign pin_o = ~(tbo_oe_i | (ext_run_i & phase_reg[2]) | clamp_i);
   always_ff @(posedge clk_i) begin
      phase_reg <= ext_run_i ? phase_reg + 3'h1 : 3'h0;
   end
   // Pulses last 4 cycles each way, above the least visible width
   task automatic pulse(input logic trig, input logic mr);
      @(posedge clk_i);
      trigger_o <= trig;
      master_reset_o <= mr;
      repeat (4) @(posedge clk_i);
      trigger_o <= 1'b0;
      master_reset_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : pulse
endmodule : timer_partner
